// File: src/lsdc_pkg.sv
// constants for the low-side driver control block
package lsdc_pkg;
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 8;
  localparam logic [7:0]  CTRL_OFFSET     = 8'h30;
  localparam logic [7:0]  STAT_OFFSET     = 8'h31;
  localparam logic [7:0]  KEY_OFFSET      = 8'h32;
  localparam logic [3:0]  UNLOCK_CODE     = 4'h5;
  localparam logic [3:0]  KEY_RESET       = 4'h0;
  localparam logic [7:0]  CTRL_RESET      = 8'h00;
  localparam logic [7:0]  CTRL_WMASK      = 8'hBF;
  localparam int          CTRL_EN1_BIT    = 0;
  localparam int          CTRL_EN2_BIT    = 1;
  localparam int          CTRL_MOD1_BIT   = 2;
  localparam int          CTRL_MOD2_BIT   = 3;
  localparam int          CTRL_SEL1_BIT   = 4;
  localparam int          CTRL_SEL2_BIT   = 5;
  localparam int          CTRL_OTIE_BIT   = 7;
  localparam int          STAT_OT_BIT     = 7;
  localparam int          STAT_OL1_BIT    = 0;
  localparam int          STAT_OL2_BIT    = 1;
  localparam int          STAT_CL1_BIT    = 2;
  localparam int          STAT_CL2_BIT    = 3;
  localparam int          KEY_MSB         = 3;
  typedef enum logic [1:0] {LSDC_MODE_NORMAL, LSDC_MODE_SLEEP, LSDC_MODE_STOP} lsdc_mode_t;
endpackage

// File: src/lsdc_event_flag.sv
// sticky event flag with rising-edge capture and clear by read
`timescale 1ns/10ps
module lsdc_event_flag
(
  input  wire logic clock_i,
  input  wire logic rst_b_i,
  input  wire logic cond_i,
  input  wire logic clear_i,
  output logic      rise_o,
  output logic      flag_o
);
  logic cond_reg;

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      cond_reg <= 1'b0;
    else
      cond_reg <= cond_i;
  end

  // one event per appearance of the condition
  assign rise_o = cond_i & ~cond_reg;

  // set wins over a clear in the same cycle
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      flag_o <= 1'b0;
    else if (rise_o)
      flag_o <= 1'b1;
    else if (clear_i)
      flag_o <= 1'b0;
  end
endmodule

// File: src/lsdc_top.sv
// low-side driver control: unlock key, enables, protection and status
// Function
// RQ1: key bits 3-0, only 0x5 unlocks control
// RQ2: each switch follows its own enable bit
// RQ3: unlock needed after reset and overvoltage
// RQ4: software trims threshold then enables drivers
// RQ5: regulator overvoltage switches both drivers off
// RQ6: overvoltage clears both enable bits
// RQ7: overvoltage condition bit follows condition
// RQ8: overvoltage interrupt enabled, cleared by read
// RQ9: new overvoltage interrupt needs new condition
// RQ10: software unlocks, waits condition clear, re-enables
// RQ11: open-load flag while current below threshold
// RQ12: no open-load indication while driver off
// RQ13: current-limit flag while limiting
// RQ14: overtemperature shuts down, latches source flag
// RQ15: overtemperature request only when mask set
// RQ16: control write re-enables after overtemperature
// RQ17: drivers active only in normal mode
// RQ18: modulation enable, channel select, otie bit
// RQ19: status overtemp bit, read clears flag
// RQ20: enable writes ignored while locked
`timescale 1ns/10ps
module lsdc_top
(
  input  wire logic                       clock_i,
  input  wire logic                       rst_b_i,
  // register port
  input  wire logic [lsdc_pkg::ADDR_W-1:0] reg_addr_i,
  input  wire logic [lsdc_pkg::DATA_W-1:0] reg_wdata_i,
  input  wire logic                       reg_wr_i,
  input  wire logic                       reg_rd_i,
  output logic      [lsdc_pkg::DATA_W-1:0] reg_rdata_o,
  // system
  input  wire lsdc_pkg::lsdc_mode_t        power_mode_i,
  input  wire logic                       pwm_channel0_i,
  input  wire logic                       pwm_channel1_i,
  // voltage regulator monitor
  input  wire logic                       regulator_ov_i,
  input  wire logic                       regulator_ov_irq_enable_i,
  input  wire logic                       regulator_ov_status_read_i,
  output logic                            regulator_ov_condition_o,
  output logic                            regulator_ov_irq_o,
  // interrupt control module
  input  wire logic                       driver_irq_mask_bit_i,
  output logic                            overtemp_source_o,
  output logic                            overtemp_irq_o,
  // analog switches
  input  wire logic                       overtemp_i,
  input  wire logic                       open_load_one_i,
  input  wire logic                       open_load_two_i,
  input  wire logic                       current_limit_one_i,
  input  wire logic                       current_limit_two_i,
  output logic                            switch_one_on_o,
  output logic                            switch_two_on_o
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] driver_control_register;
  logic [3:0] unlock_key_register;
  logic       ot_shutdown_reg;
  logic       ov_rise;
  logic       ot_rise;
  logic       ot_flag;
  logic       ov_flag;
  logic       unlocked;
  logic       ctrl_wr;
  logic       key_wr;
  logic       stat_rd;
  logic [1:0] drive_req;
  logic [1:0] drive_gate;
  logic [7:0] status_value;

  localparam int CFG_MSB = lsdc_pkg::DATA_W - 1;
  localparam logic [CFG_MSB-lsdc_pkg::CTRL_MOD1_BIT:0] CFG_MASK =
    lsdc_pkg::CTRL_WMASK[CFG_MSB:lsdc_pkg::CTRL_MOD1_BIT];

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic lsdc_hit
  (
    input logic                        strobe,
    input logic [lsdc_pkg::ADDR_W-1:0] addr,
    input logic [lsdc_pkg::ADDR_W-1:0] offset
  );
    return strobe && (addr == offset);
  endfunction

  // a modulated switch is on only while its enable and its channel are high
  function automatic logic lsdc_modulate
  (
    input logic enable,
    input logic mod_on,
    input logic sel_one,
    input logic channel0,
    input logic channel1
  );
    logic chosen;
    chosen = sel_one ? channel1 : channel0;
    return enable && (!mod_on || chosen);
  endfunction

  assign ctrl_wr  = lsdc_hit(reg_wr_i, reg_addr_i, lsdc_pkg::CTRL_OFFSET);
  assign key_wr   = lsdc_hit(reg_wr_i, reg_addr_i, lsdc_pkg::KEY_OFFSET);
  assign stat_rd  = lsdc_hit(reg_rd_i, reg_addr_i, lsdc_pkg::STAT_OFFSET);
  assign unlocked = (unlock_key_register == lsdc_pkg::UNLOCK_CODE); // RQ1

  // key is lost on overvoltage, so a fresh unlock is needed
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      unlock_key_register <= lsdc_pkg::KEY_RESET; // RQ3
    else if (ov_rise)
      unlock_key_register <= lsdc_pkg::KEY_RESET; // RQ3
    else if (key_wr)
      unlock_key_register <= reg_wdata_i[lsdc_pkg::KEY_MSB:0]; // RQ1
  end

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      driver_control_register <= lsdc_pkg::CTRL_RESET;
    else if (regulator_ov_i)
    begin
      // hold enables low for the whole condition
      driver_control_register[lsdc_pkg::CTRL_EN1_BIT] <= 1'b0; // RQ6
      driver_control_register[lsdc_pkg::CTRL_EN2_BIT] <= 1'b0; // RQ6
      if (ctrl_wr)
        driver_control_register[CFG_MSB:lsdc_pkg::CTRL_MOD1_BIT]
          <= reg_wdata_i[CFG_MSB:lsdc_pkg::CTRL_MOD1_BIT] & CFG_MASK; // RQ18
    end
    else if (ctrl_wr)
    begin
      driver_control_register[CFG_MSB:lsdc_pkg::CTRL_MOD1_BIT]
        <= reg_wdata_i[CFG_MSB:lsdc_pkg::CTRL_MOD1_BIT] & CFG_MASK; // RQ18
      if (unlocked)
        driver_control_register[lsdc_pkg::CTRL_EN2_BIT:lsdc_pkg::CTRL_EN1_BIT]
          <= reg_wdata_i[lsdc_pkg::CTRL_EN2_BIT:lsdc_pkg::CTRL_EN1_BIT]; // RQ20
    end
  end

  // ----------------------------------------------------------------
  // overtemperature shutdown
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      ot_shutdown_reg <= 1'b0;
    else if (overtemp_i)
      ot_shutdown_reg <= 1'b1; // RQ14
    else if (ctrl_wr)
      ot_shutdown_reg <= 1'b0; // RQ16
  end

  lsdc_event_flag u_ot_flag
  (
    .clock_i (clock_i),
    .rst_b_i (rst_b_i),
    .cond_i  (overtemp_i),
    .clear_i (stat_rd), // RQ19
    .rise_o  (ot_rise),
    .flag_o  (ot_flag)
  );

  assign overtemp_source_o = ot_flag; // RQ14
  // otie in control and the mask bit from the controller both gate the request here
  assign overtemp_irq_o    = ot_flag && driver_irq_mask_bit_i
                             && driver_control_register[lsdc_pkg::CTRL_OTIE_BIT]; // RQ15

  // ----------------------------------------------------------------
  // regulator overvoltage
  // ----------------------------------------------------------------
  lsdc_event_flag u_ov_flag
  (
    .clock_i (clock_i),
    .rst_b_i (rst_b_i),
    .cond_i  (regulator_ov_i),
    .clear_i (regulator_ov_status_read_i), // RQ8
    .rise_o  (ov_rise),
    .flag_o  (ov_flag)
  );

  assign regulator_ov_condition_o = regulator_ov_i; // RQ7
  assign regulator_ov_irq_o       = ov_flag && regulator_ov_irq_enable_i; // RQ8 RQ9

  // ----------------------------------------------------------------
  // switch drive
  // ----------------------------------------------------------------
  always_comb
  begin
    drive_req[0] = lsdc_modulate(driver_control_register[lsdc_pkg::CTRL_EN1_BIT],
                                 driver_control_register[lsdc_pkg::CTRL_MOD1_BIT],
                                 driver_control_register[lsdc_pkg::CTRL_SEL1_BIT],
                                 pwm_channel0_i, pwm_channel1_i); // RQ2 RQ18
    drive_req[1] = lsdc_modulate(driver_control_register[lsdc_pkg::CTRL_EN2_BIT],
                                 driver_control_register[lsdc_pkg::CTRL_MOD2_BIT],
                                 driver_control_register[lsdc_pkg::CTRL_SEL2_BIT],
                                 pwm_channel0_i, pwm_channel1_i); // RQ2 RQ18
    case (power_mode_i)
      lsdc_pkg::LSDC_MODE_NORMAL: drive_gate = drive_req; // RQ17
      default:                    drive_gate = 2'b00;     // RQ17
    endcase
    if (regulator_ov_i || ot_shutdown_reg || overtemp_i || !unlocked)
      drive_gate = 2'b00; // RQ5 RQ14 RQ3
  end

  // drive outputs registered to keep them glitch free
  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      switch_one_on_o <= 1'b0;
      switch_two_on_o <= 1'b0;
    end
    else
    begin
      switch_one_on_o <= drive_gate[0] && !regulator_ov_i; // RQ5
      switch_two_on_o <= drive_gate[1] && !regulator_ov_i; // RQ5
    end
  end

  // ----------------------------------------------------------------
  // status and read data
  // ----------------------------------------------------------------
  always_comb
  begin
    status_value = 8'h00;
    status_value[lsdc_pkg::STAT_OT_BIT] = overtemp_i || ot_shutdown_reg; // RQ19
    status_value[lsdc_pkg::STAT_CL2_BIT] = current_limit_two_i; // RQ13
    status_value[lsdc_pkg::STAT_CL1_BIT] = current_limit_one_i; // RQ13
    status_value[lsdc_pkg::STAT_OL2_BIT] = open_load_two_i && switch_two_on_o; // RQ11 RQ12
    status_value[lsdc_pkg::STAT_OL1_BIT] = open_load_one_i && switch_one_on_o; // RQ11 RQ12
  end

  always_ff @(posedge clock_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      reg_rdata_o <= 8'h00;
    else if (reg_rd_i)
    begin
      case (reg_addr_i)
        lsdc_pkg::CTRL_OFFSET: reg_rdata_o <= driver_control_register;
        lsdc_pkg::STAT_OFFSET: reg_rdata_o <= status_value;
        lsdc_pkg::KEY_OFFSET:  reg_rdata_o <= {4'h0, unlock_key_register};
        default:               reg_rdata_o <= 8'h00;
      endcase
    end
  end
endmodule

// File: tb/lsdc_top_sva.sv
// port assertions for the low-side driver control block
`timescale 1ns/10ps
module lsdc_top_sva
(
  input wire logic                 clock_i,
  input wire logic                 rst_b_i,
  input wire lsdc_pkg::lsdc_mode_t power_mode_i,
  input wire logic                 regulator_ov_i,
  input wire logic                 regulator_ov_irq_enable_i,
  input wire logic                 regulator_ov_irq_o,
  input wire logic                 driver_irq_mask_bit_i,
  input wire logic                 overtemp_source_o,
  input wire logic                 overtemp_irq_o,
  input wire logic                 overtemp_i,
  input wire logic                 switch_one_on_o,
  input wire logic                 switch_two_on_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  wire off = !switch_one_on_o && !switch_two_on_o;
  a_ov_off: assert property (regulator_ov_i |=> off) else $error("switch on in ov");
  a_mode_off: assert property (power_mode_i != lsdc_pkg::LSDC_MODE_NORMAL |=> off)
    else $error("switch on outside normal");
  a_ot_off: assert property (overtemp_i |=> off) else $error("switch on in overtemp");
  a_ot_latch: assert property ($rose(overtemp_i) |=> overtemp_source_o)
    else $error("overtemp not latched");
  a_ot_mask: assert property (overtemp_irq_o |->
    driver_irq_mask_bit_i && overtemp_source_o) else $error("unmasked overtemp irq");
  a_ov_gate: assert property (regulator_ov_irq_o |-> regulator_ov_irq_enable_i)
    else $error("ov irq while disabled");
  a_ov_raise: assert property ($rose(regulator_ov_i) ##1 regulator_ov_irq_enable_i |->
    regulator_ov_irq_o) else $error("ov irq missing");
  a_ov_rearm: assert property (regulator_ov_i && $past(regulator_ov_i) && $past(rst_b_i) &&
    regulator_ov_irq_enable_i && !regulator_ov_irq_o |=> !regulator_ov_irq_o)
    else $error("ov irq without new rise");
endmodule
bind lsdc_top lsdc_top_sva u_sva
(
  .clock_i                   (clock_i),
  .rst_b_i                   (rst_b_i),
  .power_mode_i              (power_mode_i),
  .regulator_ov_i            (regulator_ov_i),
  .regulator_ov_irq_enable_i (regulator_ov_irq_enable_i),
  .regulator_ov_irq_o        (regulator_ov_irq_o),
  .driver_irq_mask_bit_i     (driver_irq_mask_bit_i),
  .overtemp_source_o         (overtemp_source_o),
  .overtemp_irq_o            (overtemp_irq_o),
  .overtemp_i                (overtemp_i),
  .switch_one_on_o           (switch_one_on_o),
  .switch_two_on_o           (switch_two_on_o)
);

// File: tb/lsdc_switch_model.sv
// behavioural analog switches and protection comparators
`timescale 1ns/10ps
module lsdc_switch_model
(
  input  wire logic [1:0] on_i,
  input  wire logic [4:0] fault_i,
  output logic      [1:0] open_load_o,
  output logic      [1:0] current_limit_o,
  output logic            overtemp_o
);
  // an idle switch carries no current, so its raw comparator reads open
  assign open_load_o = ~on_i | fault_i[1:0];
  assign current_limit_o = on_i & fault_i[3:2];
  assign overtemp_o = fault_i[4];
endmodule

// File: tb/lsdc_top_tb.sv
// directed bench for the low-side driver control block
`timescale 1ns/10ps
module lsdc_top_tb;
  logic        clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, ov = 1'b0, ov_ie = 1'b0;
  logic        ov_rd = 1'b0, mask = 1'b0, ov_cond, ov_irq, ot_src, ot_irq;
  logic        pwm0 = 1'b0, pwm1 = 1'b0;
  logic [1:0]  mode = 2'h0;
  logic [4:0]  flt = 5'h00;
  logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata;
  logic [19:0] op;
  wire  [1:0]  sw, ol, cl;
  wire         ot;
  int          n_mismatch = 0, tests_run = 0;
  // op digit: 0 write, 1 read, 2 drive {ov_rd,mask,ov_ie,ov,mode} {pwm1,pwm0,faults}, 3 look
  localparam logic [19:0] PROG [70] = '{20'h13000, 20'h13100, 20'h13200,
    20'h03003, 20'h30000, 20'h032FA, 20'h1320A, 20'h03003, 20'h30000,
    20'h03205, 20'h03002, 20'h30002, 20'h030FF, 20'h130BF, 20'h03003,
    20'h20009, 20'h13109, 20'h03002, 20'h13108,
    20'h20100, 20'h30000, 20'h20200, 20'h30000, 20'h20000, 20'h30002,
    20'h03003, 20'h20C00, 20'h30030, 20'h13000, 20'h13200,
    20'h22C00, 20'h30010, 20'h20C00, 20'h03205, 20'h03003, 20'h30010,
    20'h20800, 20'h30000, 20'h20C00, 20'h30030, 20'h20800, 20'h03205,
    20'h03003, 20'h30023, 20'h21000, 20'h03083, 20'h21010, 20'h300C0,
    20'h20010, 20'h30040, 20'h20000, 20'h30040, 20'h13180, 20'h30000,
    20'h03083, 20'h30003, 20'h03087, 20'h30002, 20'h20020, 20'h30003,
    20'h030BB, 20'h30001, 20'h20040, 20'h30003, 20'h20020, 20'h30001,
    20'h030B7, 20'h30002, 20'h20066, 20'h13106};
  always #2.5 clk = ~clk;
  lsdc_top DUT
  (
    .clock_i(clk), .rst_b_i(rst_b), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_rdata_o(rdata), .power_mode_i(lsdc_pkg::lsdc_mode_t'(mode)),
    .pwm_channel0_i(pwm0), .pwm_channel1_i(pwm1), .regulator_ov_i(ov),
    .regulator_ov_irq_enable_i(ov_ie), .regulator_ov_status_read_i(ov_rd),
    .regulator_ov_condition_o(ov_cond), .regulator_ov_irq_o(ov_irq),
    .driver_irq_mask_bit_i(mask), .overtemp_source_o(ot_src), .overtemp_irq_o(ot_irq),
    .overtemp_i(ot), .open_load_one_i(ol[0]), .open_load_two_i(ol[1]),
    .current_limit_one_i(cl[0]), .current_limit_two_i(cl[1]), .switch_one_on_o(sw[0]),
    .switch_two_on_o(sw[1])
  );
  lsdc_switch_model u_analog
  (
    .on_i(sw), .fault_i(flt), .open_load_o(ol), .current_limit_o(cl), .overtemp_o(ot)
  );
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    tick(1);
    {wr, rd, addr, wdata} = {w, ~w, a, d};
    tick(1);
    {wr, rd} = 2'h0;
    if (!w)
      check("rdata", rdata, d);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    #20000;
    n_mismatch++;
    stop_test();
  end
  initial
  begin
    tick(3);
    rst_b = 1'b1;
    foreach (PROG[i])
    begin
      op = PROG[i];
      case (op[19:16])
        4'h0: xfer(1'b1, op[15:8], op[7:0]);
        4'h1: xfer(1'b0, op[15:8], op[7:0]);
        4'h2: {ov_rd, mask, ov_ie, ov, mode, pwm1, pwm0, flt} = {op[13:8], op[6:0]};
        default:
        begin
          tick(1);
          check("outputs", {ot_irq, ot_src, ov_irq, ov_cond, 2'h0, sw}, op[7:0]);
        end
      endcase
    end
    stop_test();
  end
endmodule
